// ### shared/conv_pkg.sv
package conv_pkg;

    // Datapath widths
    localparam int MEAS_W    = 16;  // Measured input, unsigned, in uA
    localparam int FRAC      = 16;  // Fraction bits of the normalized result
    localparam int N_W       = 24;  // Signed normalized value, Q7.16
    localparam int SCALE_W   = 16;  // Signed scale end values
    localparam int RES_W     = 24;  // Signed display value
    localparam int PROD_W    = 41;  // N_W + SCALE_W + 1
    localparam int BORDER_W  = 18;  // Permissible range borders in uA
    localparam int LOM_W     = 10;  // Low margin, 0.1 % steps
    localparam int HIM_W     = 8;   // High margin, 0.1 % steps

    // Breakpoint table
    localparam int BP_MAX    = 20;
    localparam int BP_IDX_W  = 5;
    localparam int X_W       = 10;  // Breakpoint X in 0.1 % steps
    localparam int Y_W       = 16;  // Breakpoint Y, signed
    localparam logic [BP_IDX_W-1:0] BP_MAX_N = 5'h14;
    localparam logic [BP_IDX_W-1:0] BP_MIN_N = 5'h02;

    // Nominal ranges in uA
    localparam logic [BORDER_W-1:0] R420_START_UA = 18'h00FA0;
    localparam logic [BORDER_W-1:0] R020_START_UA = 18'h00000;
    localparam logic [BORDER_W-1:0] RANGE_END_UA  = 18'h04E20;
    localparam logic [31:0]         PERMILLE      = 32'h000003E8;
    localparam logic [31:0]         Q16_ONE       = 32'h00010000;

    localparam logic signed [PROD_W-1:0] ROUND_HALF = 41'sh00000008000;

    // Sequential units
    localparam int DIV_W      = 40;
    localparam int DEN_W      = 24;
    localparam int DIV_STEPS  = 40;
    localparam int ROOT_RAD_W = 40;
    localparam int ROOT_W     = 20;
    localparam int ROOT_STEPS = 20;
    localparam int STEP_W     = 6;

    typedef enum logic [1:0] {
        CHAR_LINEAR = 2'h0,
        CHAR_SQUARE = 2'h1,
        CHAR_ROOT   = 2'h2,
        CHAR_USER   = 2'h3
    } char_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_SHAPE   = 3'h1,
        ST_ROOT    = 3'h2,
        ST_SEARCH  = 3'h3,
        ST_DIVIDE  = 3'h4,
        ST_SEG_OUT = 3'h5,
        ST_SCALE   = 3'h6
    } conv_state_t;

    // Breakpoint X in 0.1 % to Q16 normalized position, rounded
    function automatic logic signed [N_W-1:0] pm_to_q16(
        input logic [X_W-1:0] x
    );
        logic [31:0] t;
        t = (32'(x) * Q16_ONE + (PERMILLE >> 1)) / PERMILLE;
        return N_W'(t);
    endfunction

    // Magnitude of a 25-bit signed value
    function automatic logic [24:0] mag25(input logic signed [24:0] v);
        return v[24] ? 25'(-v) : 25'(v);
    endfunction

endpackage

// ### design/seq_sqrt.sv
`timescale 1ns/1ps
module seq_sqrt
    import conv_pkg::*;
(
    input  wire logic                  ref_clk_i,  // System clock
    input  wire logic                  sys_rst_i,  // Sync reset, high
    input  wire logic                  start_i,    // Start pulse
    input  wire logic [ROOT_RAD_W-1:0] radicand_i, // Unsigned radicand
    output logic                       done_o,     // Root valid pulse
    output logic      [ROOT_W-1:0]     root_o      // Integer root
);

    logic                  busy_q, busy_d;
    logic                  done_q, done_d;
    logic [STEP_W-1:0]     step_q, step_d;
    logic [ROOT_RAD_W-1:0] rad_q, rad_d;
    logic [ROOT_W+1:0]     rem_q, rem_d;
    logic [ROOT_W-1:0]     root_q, root_d;
    logic [ROOT_W+1:0]     rem_s;
    logic [ROOT_W+1:0]     trial;

    // Two radicand bits per step, one root bit per step
    always_comb begin
        busy_d = busy_q;
        done_d = 1'b0;
        step_d = step_q;
        rad_d  = rad_q;
        rem_d  = rem_q;
        root_d = root_q;
        rem_s  = {rem_q[ROOT_W-1:0], rad_q[ROOT_RAD_W-1 -: 2]};
        trial  = {root_q, 2'b01};
        if (start_i && !busy_q) begin
            busy_d = 1'b1;
            step_d = '0;
            rad_d  = radicand_i;
            rem_d  = '0;
            root_d = '0;
        end else if (busy_q) begin
            rad_d = {rad_q[ROOT_RAD_W-3:0], 2'b00};
            if (rem_s >= trial) begin
                rem_d  = rem_s - trial;
                root_d = {root_q[ROOT_W-2:0], 1'b1};
            end else begin
                rem_d  = rem_s;
                root_d = {root_q[ROOT_W-2:0], 1'b0};
            end
            step_d = step_q + 6'h01;
            if (step_q == STEP_W'(ROOT_STEPS - 1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            step_q <= '0;
            rad_q  <= '0;
            rem_q  <= '0;
            root_q <= '0;
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            step_q <= step_d;
            rad_q  <= rad_d;
            rem_q  <= rem_d;
            root_q <= root_d;
        end
    end

    assign done_o = done_q;
    assign root_o = root_q;

endmodule

// ### design/characteristic_conversion.sv
`timescale 1ns/1ps
// What this block does
// - Normalize: subtract range start, divide by 16 mA or 20 mA width.
// - Linear: normalized times (scale high minus scale low) plus scale low.
// - Square: normalized squared, times scale span, plus scale low.
// - Root: square root of normalized, times scale span, plus scale low.
// - Root with negative normalized value outputs exactly scale low.
// - User table holds 2 to 20 X-Y breakpoints forming linear segments.
// - User mode picks segment whose breakpoint X values bracket the input.
// - Segment value: offset from lower point times slope, plus lower Y.
// - Above 1 the last segment (final two points) is extrapolated.
// - Below 0 the first segment (first two points) is extrapolated.
// - Borders: start minus low margin share, end plus high margin share.
module characteristic_conversion
    import conv_pkg::*;
(
    input  wire logic                       ref_clk_i,          // Clock
    input  wire logic                       sys_rst_i,          // Sync reset
    input  wire logic                       start_i,            // Convert
    input  wire logic [MEAS_W-1:0]          meas_i,             // Input, uA
    input  wire logic                       range_420_i,        // 1: 4-20
    input  wire logic [1:0]                 char_sel_i,         // Curve
    input  wire logic signed [SCALE_W-1:0]  scale_low_value_i,  // At 0
    input  wire logic signed [SCALE_W-1:0]  scale_high_value_i, // At 1
    input  wire logic [LOM_W-1:0]           low_range_margin_i, // 0.1 %
    input  wire logic [HIM_W-1:0]           high_range_margin_i,// 0.1 %
    input  wire logic [BP_IDX_W-1:0]        bp_count_i,         // Points
    input  wire logic                       bp_we_i,            // Pt write
    input  wire logic [BP_IDX_W-1:0]        bp_idx_i,           // Pt index
    input  wire logic [X_W-1:0]             bp_x_i,             // Pt X
    input  wire logic signed [Y_W-1:0]      bp_y_i,             // Pt Y
    output logic                            busy_o,             // Working
    output logic                            valid_o,            // Result
    output logic signed [RES_W-1:0]         result_o,           // Display
    output logic signed [N_W-1:0]           norm_o,             // Q16 norm
    output logic [BORDER_W-1:0]             border_low_o,       // uA
    output logic [BORDER_W-1:0]             border_high_o       // uA
);

    // Breakpoint table, written by the configuration side
    logic [X_W-1:0]        bp_x_mem [BP_MAX];
    logic signed [Y_W-1:0] bp_y_mem [BP_MAX];

    always_ff @(posedge ref_clk_i) begin
        if (bp_we_i && bp_idx_i < BP_MAX_N) begin
            bp_x_mem[bp_idx_i] <= bp_x_i;
            bp_y_mem[bp_idx_i] <= bp_y_i;
        end
    end

    conv_state_t             state_q, state_d;
    logic signed [N_W-1:0]   n_q, n_d;
    logic signed [N_W-1:0]   f_q, f_d;
    logic [BP_IDX_W-1:0]     idx_q, idx_d;
    logic [DIV_W-1:0]        num_q, num_d;
    logic [DEN_W:0]          rem_q, rem_d;
    logic [DEN_W-1:0]        den_q, den_d;
    logic                    neg_q, neg_d;
    logic signed [Y_W-1:0]   ylo_q, ylo_d;
    logic [STEP_W-1:0]       step_q, step_d;
    logic signed [RES_W-1:0] result_q, result_d;
    logic                    valid_q, valid_d;
    logic [BORDER_W-1:0]     blo_q, blo_d;
    logic [BORDER_W-1:0]     bhi_q, bhi_d;

    logic                    root_start;
    logic                    root_done;
    logic [ROOT_W-1:0]       root_val;

    logic [BP_IDX_W-1:0]     cnt_eff;
    logic [BP_IDX_W-1:0]     last_seg;
    logic [BP_IDX_W-1:0]     idx_nx;
    logic signed [N_W-1:0]   ip_lo, ip_hi;
    logic signed [24:0]      diff, dy, dx;
    logic [49:0]             seg_prod;
    logic signed [47:0]      sq;
    logic signed [PROD_W-1:0] span_prod;
    logic signed [PROD_W-1:0] scaled;
    logic signed [16:0]      span;
    logic [DEN_W:0]          rem_s;
    logic [DIV_W-1:0]        q_round;
    logic signed [RES_W-1:0] q_signed;
    logic [BORDER_W-1:0]     start_ua;
    logic [31:0]             lo_cut, hi_add;

    // Normalized value in Q16, exact constant division by range width
    function automatic logic signed [N_W-1:0] normalize(
        input logic [MEAS_W-1:0] m,
        input logic              r420
    );
        logic signed [33:0] num;
        logic signed [33:0] wid;
        logic signed [33:0] st;
        st  = r420 ? 34'(signed'({R420_START_UA, 16'h0000})) : 34'sh0;
        wid = r420 ? 34'(RANGE_END_UA - R420_START_UA)
                   : 34'(RANGE_END_UA - R020_START_UA);
        num = 34'(signed'({2'b00, m, 16'h0000})) - st;
        return N_W'(num / wid);
    endfunction

    seq_sqrt u_sqrt (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (root_start),
        .radicand_i ({n_q[N_W-1:0], 16'h0000}),
        .done_o     (root_done),
        .root_o     (root_val)
    );

    always_comb begin
        // Out-of-range counts are clamped rather than refused
        if (bp_count_i < BP_MIN_N) begin
            cnt_eff = BP_MIN_N;
        end else if (bp_count_i > BP_MAX_N) begin
            cnt_eff = BP_MAX_N;
        end else begin
            cnt_eff = bp_count_i;
        end
        last_seg = cnt_eff - BP_MIN_N;
        idx_nx   = idx_q + 5'h01;
        ip_lo    = pm_to_q16(bp_x_mem[idx_q]);
        ip_hi    = pm_to_q16(bp_x_mem[idx_nx]);
        diff     = 25'(n_q) - 25'(ip_lo);
        dy       = 25'(bp_y_mem[idx_nx]) - 25'(bp_y_mem[idx_q]);
        dx       = 25'(ip_hi) - 25'(ip_lo);
        seg_prod = mag25(diff) * mag25(dy);
        sq       = 48'(n_q) * 48'(n_q) + 48'(ROUND_HALF);
        span     = 17'(scale_high_value_i) - 17'(scale_low_value_i);
        span_prod = PROD_W'(f_q) * PROD_W'(span);
        scaled   = ((span_prod + ROUND_HALF) >>> FRAC)
                   + PROD_W'(scale_low_value_i);
        rem_s    = {rem_q[DEN_W-1:0], num_q[DIV_W-1]};
        q_round  = (num_q + 40'h0000000001) >> 1;
        q_signed = neg_q ? RES_W'(-q_round[RES_W-1:0])
                         : RES_W'(q_round[RES_W-1:0]);

        state_d    = state_q;
        n_d        = n_q;
        f_d        = f_q;
        idx_d      = idx_q;
        num_d      = num_q;
        rem_d      = rem_q;
        den_d      = den_q;
        neg_d      = neg_q;
        ylo_d      = ylo_q;
        step_d     = step_q;
        result_d   = result_q;
        valid_d    = 1'b0;
        root_start = 1'b0;

        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    n_d     = normalize(meas_i, range_420_i);
                    state_d = ST_SHAPE;
                end
            end
            ST_SHAPE: begin
                case (char_sel_i)
                    CHAR_LINEAR: begin
                        f_d     = n_q;
                        state_d = ST_SCALE;
                    end
                    CHAR_SQUARE: begin
                        f_d     = N_W'(sq >>> FRAC);
                        state_d = ST_SCALE;
                    end
                    CHAR_ROOT: begin
                        if (n_q < 0) begin
                            // Zero factor leaves exactly the low end
                            f_d     = '0;
                            state_d = ST_SCALE;
                        end else begin
                            root_start = 1'b1;
                            state_d    = ST_ROOT;
                        end
                    end
                    default: begin
                        idx_d   = '0;
                        state_d = ST_SEARCH;
                    end
                endcase
            end
            ST_ROOT: begin
                if (root_done) begin
                    f_d     = N_W'(root_val);
                    state_d = ST_SCALE;
                end
            end
            ST_SEARCH: begin
                // First segment catches n < 0, last one n > 1
                if (idx_q == last_seg || n_q < ip_hi) begin
                    num_d   = {seg_prod[DIV_W-2:0], 1'b0};
                    den_d   = DEN_W'(mag25(dx));
                    neg_d   = diff[24] ^ dy[24] ^ dx[24];
                    ylo_d   = bp_y_mem[idx_q];
                    rem_d   = '0;
                    step_d  = '0;
                    state_d = ST_DIVIDE;
                end else begin
                    idx_d = idx_nx;
                end
            end
            ST_DIVIDE: begin
                // Restoring divide, one quotient bit per cycle
                if (rem_s >= {1'b0, den_q}) begin
                    rem_d = rem_s - {1'b0, den_q};
                    num_d = {num_q[DIV_W-2:0], 1'b1};
                end else begin
                    rem_d = rem_s;
                    num_d = {num_q[DIV_W-2:0], 1'b0};
                end
                step_d = step_q + 6'h01;
                if (step_q == STEP_W'(DIV_STEPS - 1)) begin
                    state_d = ST_SEG_OUT;
                end
            end
            ST_SEG_OUT: begin
                result_d = RES_W'(ylo_q) + q_signed;
                valid_d  = 1'b1;
                state_d  = ST_IDLE;
            end
            ST_SCALE: begin
                result_d = RES_W'(scaled);
                valid_d  = 1'b1;
                state_d  = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Permissible input borders follow the margin inputs continuously
    always_comb begin
        start_ua = range_420_i ? R420_START_UA : R020_START_UA;
        lo_cut   = (32'(start_ua) * 32'(low_range_margin_i)) / PERMILLE;
        hi_add   = (32'(RANGE_END_UA) * 32'(high_range_margin_i))
                   / PERMILLE;
        blo_d    = start_ua - BORDER_W'(lo_cut);
        bhi_d    = RANGE_END_UA + BORDER_W'(hi_add);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q  <= ST_IDLE;
            n_q      <= '0;
            f_q      <= '0;
            idx_q    <= '0;
            num_q    <= '0;
            rem_q    <= '0;
            den_q    <= '0;
            neg_q    <= 1'b0;
            ylo_q    <= '0;
            step_q   <= '0;
            result_q <= '0;
            valid_q  <= 1'b0;
            blo_q    <= '0;
            bhi_q    <= '0;
        end else begin
            state_q  <= state_d;
            n_q      <= n_d;
            f_q      <= f_d;
            idx_q    <= idx_d;
            num_q    <= num_d;
            rem_q    <= rem_d;
            den_q    <= den_d;
            neg_q    <= neg_d;
            ylo_q    <= ylo_d;
            step_q   <= step_d;
            result_q <= result_d;
            valid_q  <= valid_d;
            blo_q    <= blo_d;
            bhi_q    <= bhi_d;
        end
    end

    assign busy_o        = (state_q != ST_IDLE);
    assign valid_o       = valid_q;
    assign result_o      = result_q;
    assign norm_o        = n_q;
    assign border_low_o  = blo_q;
    assign border_high_o = bhi_q;

endmodule

// ### sim/conv_chk_sva.sv
`timescale 1ns/1ps
module conv_chk
    import conv_pkg::*;
(
    input wire logic                      ref_clk_i,           // Clock
    input wire logic                      sys_rst_i,           // Reset
    input wire logic                      start_i,             // Start
    input wire logic [MEAS_W-1:0]         meas_i,              // Input
    input wire logic                      range_420_i,         // Range
    input wire logic [1:0]                char_sel_i,          // Curve
    input wire logic signed [SCALE_W-1:0] scale_low_value_i,   // Low end
    input wire logic [LOM_W-1:0]          low_range_margin_i,  // Margin
    input wire logic [HIM_W-1:0]          high_range_margin_i, // Margin
    input wire logic                      busy_o,              // Busy
    input wire logic                      valid_o,             // Valid
    input wire logic signed [RES_W-1:0]   result_o,            // Value
    input wire logic signed [N_W-1:0]     norm_o,              // Norm
    input wire logic [BORDER_W-1:0]       border_low_o,        // Border
    input wire logic [BORDER_W-1:0]       border_high_o        // Border
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [1:0] up_q;
    logic [1:0] up_d;

    // Borders lag their inputs, so they are judged only once settled
    always_comb begin
        up_d = up_q + {1'b0, up_q != 2'h3};
        if (sys_rst_i) begin
            up_d = 2'h0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        up_q <= up_d;
    end

    function automatic logic signed [N_W-1:0] f_norm(
        input logic [MEAS_W-1:0] m, input logic r);
        longint d;
        d = (longint'(m) - (r ? 4000 : 0)) * 65536;
        return N_W'(d / (r ? 16000 : 20000));
    endfunction

    wire take = start_i && !busy_o;

    property p_norm;
        take |=> norm_o == f_norm($past(meas_i), $past(range_420_i));
    endproperty
    property p_lin;
        take && !char_sel_i[1] |=> !valid_o [*2] ##1 valid_o;
    endproperty
    property p_root_neg;
        take && char_sel_i == 2'h2 && range_420_i && meas_i < 16'h0FA0
            |-> ##3 valid_o && result_o == scale_low_value_i;
    endproperty
    property p_root;
        take && char_sel_i == 2'h2 && !(range_420_i && meas_i < 16'h0FA0)
            |-> ##24 valid_o;
    endproperty
    property p_user;
        take && char_sel_i == 2'h3 |=> !valid_o [*8] ##[36:54] valid_o;
    endproperty
    property p_pulse;
        valid_o |=> !valid_o;
    endproperty
    property p_hold;
        !valid_o |-> $stable(result_o);
    endproperty
    // The result cycle is already idle, so a new start may follow it
    property p_idle;
        valid_o |-> !busy_o;
    endproperty
    property p_blo;
        up_q == 2'h3 |-> border_low_o == ($past(range_420_i) ?
            18'h00FA0 - 18'(4 * $past(low_range_margin_i)) : 18'h00000);
    endproperty
    property p_bhi;
        up_q == 2'h3 |-> border_high_o ==
            18'h04E20 + 18'(20 * $past(high_range_margin_i));
    endproperty

    a_norm: assert property (p_norm)
        else $error("normalized value wrong");
    a_lin: assert property (p_lin)
        else $error("linear or square latency wrong");
    a_root_neg: assert property (p_root_neg)
        else $error("negative root not scale low");
    a_root: assert property (p_root)
        else $error("root latency wrong");
    a_user: assert property (p_user)
        else $error("user curve latency wrong");
    a_pulse: assert property (p_pulse)
        else $error("valid longer than one cycle");
    a_hold: assert property (p_hold)
        else $error("result changed without valid");
    a_idle: assert property (p_idle)
        else $error("busy still high with valid");
    a_blo: assert property (p_blo)
        else $error("low border wrong");
    a_bhi: assert property (p_bhi)
        else $error("high border wrong");

    c_user: cover property (take && char_sel_i == 2'h3);
    c_root: cover property (take && char_sel_i == 2'h2);
    c_neg: cover property (valid_o && result_o == scale_low_value_i);
endmodule

// ### sim/meas_source.sv
`timescale 1ns/1ps
module meas_source
    import conv_pkg::*;
(
    input  wire logic         ref_clk_i, // Clock
    output logic              start_o,   // Start pulse
    output logic [MEAS_W-1:0] meas_o     // Sample, uA
);
    initial begin
        start_o = 1'b0;
        meas_o = 16'h0000;
    end

    // After the taking edge the value is inverted, so a late read shows
    task automatic send(input logic [MEAS_W-1:0] m);
        @(posedge ref_clk_i);
        #1;
        start_o = 1'b1;
        meas_o = m;
        @(posedge ref_clk_i);
        #1;
        start_o = 1'b0;
        meas_o = ~m;
    endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import conv_pkg::*;
    logic ref_clk_i, sys_rst_i, start_i, range_420_i, bp_we_i, busy_o;
    logic valid_o;
    logic [MEAS_W-1:0] meas_i, m;
    logic [1:0] char_sel_i, c;
    logic signed [SCALE_W-1:0] scale_low_value_i, scale_high_value_i;
    logic [LOM_W-1:0] low_range_margin_i;
    logic [HIM_W-1:0] high_range_margin_i;
    logic [BP_IDX_W-1:0] bp_count_i, bp_idx_i;
    logic [X_W-1:0] bp_x_i;
    logic signed [Y_W-1:0] bp_y_i;
    logic signed [RES_W-1:0] result_o, w, exp_q[$];
    logic signed [N_W-1:0] norm_o;
    logic [BORDER_W-1:0] border_low_o, border_high_o;
    int num_errors = 0, cmp_count = 0, seed = 32'hd9d5, bx[20], by[20];
    int mt[3] = '{10000, 2500, 20500};
    // 0.375 of the span is an exact tie and rounds half up
    int ex_w[9] = '{263, -441, 1247, -89, -287, 1295, 619, -300, 1223};
    int cnts[5] = '{1, 2, 11, 20, 25};

    characteristic_conversion u_characteristic_conversion (
        .ref_clk_i, .sys_rst_i, .start_i, .meas_i, .range_420_i, .char_sel_i,
        .scale_low_value_i, .scale_high_value_i, .low_range_margin_i,
        .high_range_margin_i, .bp_count_i, .bp_we_i, .bp_idx_i, .bp_x_i,
        .bp_y_i, .busy_o, .valid_o, .result_o, .norm_o, .border_low_o,
        .border_high_o
    );
    meas_source u_meas_source (.ref_clk_i, .start_o(start_i), .meas_o(meas_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic ok, input string what);
        cmp_count++;
        if (!ok) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic longint ip(input int i);
        return (longint'(bx[i]) * 65536 + 500) / 1000;
    endfunction

    // Reference value, computed from the inputs as they stand now
    function automatic logic signed [RES_W-1:0] exp_val(
        input logic [1:0] c, input logic [MEAS_W-1:0] m);
        longint n, f, a, q, d, r;
        int k, cnt;
        cnt = bp_count_i < 2 ? 2 : bp_count_i > 20 ? 20 : bp_count_i;
        n = (longint'(m) - (range_420_i ? 4000 : 0)) * 65536;
        n = n / (range_420_i ? 16000 : 20000);
        r = 0;
        for (int b = 19; b >= 0; b--)
            if ((r + (64'sh1 << b)) ** 2 <= n * 65536)
                r = r + (64'sh1 << b);
        f = c == 2'h0 ? n : c == 2'h1 ? (n * n + 32768) >>> 16 : r;
        d = longint'(scale_high_value_i) - scale_low_value_i;
        if (c != 2'h3)
            return RES_W'(((f * d + 32768) >>> 16) + scale_low_value_i);
        k = 0;
        while (k < cnt - 2 && n >= ip(k + 1))
            k++;
        a = n - ip(k);
        q = by[k + 1] - by[k];
        d = ip(k + 1) - ip(k);
        f = ((a < 0 ? -a : a) * (q < 0 ? -q : q) + d / 2) / d;
        return RES_W'((((a < 0) != (q < 0)) ? -f : f) + by[k]);
    endfunction

    task automatic wr_bp(input int i, input int x, input int y);
        @(posedge ref_clk_i);
        #1;
        bp_we_i = 1'b1;
        bp_idx_i = BP_IDX_W'(i);
        bp_x_i = X_W'(x);
        bp_y_i = Y_W'(y);
        if (i < 20) begin
            bx[i] = x;
            by[i] = y;
        end
        @(posedge ref_clk_i);
        #1;
        bp_we_i = 1'b0;
    endtask

    // A poke issues a second start while busy; it must be ignored
    task automatic conv(input logic [1:0] c, input logic [MEAS_W-1:0] m,
                        input logic signed [RES_W-1:0] e, input bit poke);
        char_sel_i = c;
        exp_q.push_back(e);
        u_meas_source.send(m);
        if (poke) begin
            repeat (5) @(posedge ref_clk_i);
            u_meas_source.send(~m);
        end
        for (int i = 0; i < 100 && exp_q.size() != 0; i++)
            @(posedge ref_clk_i);
        #1;
        chk(exp_q.size() == 0, "no result");
    endtask

    always @(posedge ref_clk_i) begin
        if (valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "result without start");
            end else begin
                w = exp_q.pop_front();
                chk(result_o === w, "result mismatch");
            end
        end
    end

    initial begin
        #400000;
        num_errors++;
        $display("unexpected at %0t: timeout", $time);
        final_report();
    end

    initial begin
        sys_rst_i = 1'b1;
        {bp_we_i, bp_idx_i, bp_x_i, bp_y_i, char_sel_i} = '0;
        bp_count_i = 5'h02;
        range_420_i = 1'b1;
        scale_low_value_i = 16'hFED4;
        scale_high_value_i = 16'h04B0;
        low_range_margin_i = 10'h0C8;
        high_range_margin_i = 8'h64;
        repeat (16) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk(border_low_o === 18'h00C80, "low border");
        chk(border_high_o === 18'h055F0, "high border");
        for (int k = 0; k < 9; k++)
            conv(2'(k / 3), 16'(mt[k % 3]), 24'(ex_w[k]),
                 1'b0);
        for (int i = 0; i < 20; i++)
            wr_bp(i, i * 50 + $unsigned($random(seed)) % 40,
                  $random(seed) % 2000);
        wr_bp(20, 0, 32767);
        foreach (cnts[j]) begin
            bp_count_i = 5'(cnts[j]);
            for (int k = 0; k < 8; k++) begin
                c = 2'(k);
                range_420_i = (k == 3) ? 1'b1 : 1'($random(seed));
                scale_low_value_i = 16'($random(seed) % 1000);
                scale_high_value_i = 16'($random(seed) % 3000);
                low_range_margin_i = 10'($unsigned($random(seed)) % 1000);
                high_range_margin_i = 8'($unsigned($random(seed)) % 200);
                m = (k == 3) ? 16'h0000 : (k == 7) ? 16'h61A8
                    : 16'($unsigned($random(seed)) % 25000);
                conv(c, m, exp_val(c, m), k == 7);
            end
        end
        final_report();
    end
endmodule

bind characteristic_conversion conv_chk u_conv_chk (
    .ref_clk_i, .sys_rst_i, .start_i, .meas_i, .range_420_i, .char_sel_i,
    .scale_low_value_i, .low_range_margin_i, .high_range_margin_i,
    .busy_o, .valid_o, .result_o, .norm_o, .border_low_o, .border_high_o
);
